// ==== pkg/bscr_map.svh ====
// register indices, fixed read values, reset values and masks of the bank
`ifndef BSCR_MAP_SVH
`define BSCR_MAP_SVH

// register indices; the byte address is four times the index
`define BSCR_IDX_TYPE_BOARD    9'h000
`define BSCR_IDX_LOGIC_REV     9'h002
`define BSCR_IDX_TEST_ONE      9'h004
`define BSCR_IDX_TEST_TWO      9'h006
`define BSCR_IDX_BOARD_IDENTITY      9'h008
`define BSCR_IDX_ASSEMBLY      9'h00A
`define BSCR_IDX_IRQ_STATUS    9'h00C
`define BSCR_IDX_PLL_STATUS    9'h00E
`define BSCR_IDX_CARRIER_SLOT  9'h010
`define BSCR_IDX_ETH_ERRORS    9'h020
`define BSCR_IDX_PCS_ERRORS    9'h022
`define BSCR_IDX_UNIT_RESET    9'h100
`define BSCR_IDX_LED_CTRL      9'h102
`define BSCR_IDX_IRQ_ENABLE    9'h10C
`define BSCR_IDX_TCLK_A        9'h10E
`define BSCR_IDX_TCLK_B        9'h110
`define BSCR_IDX_TCLK_C        9'h112
`define BSCR_IDX_TCLK_D        9'h114
`define BSCR_IDX_REF_ZERO      9'h116
`define BSCR_IDX_REF_ONE       9'h118
`define BSCR_IDX_UNDEFINED     9'h11A
`define BSCR_IDX_RSVD_A        9'h11C
`define BSCR_IDX_RSVD_B        9'h11E
`define BSCR_IDX_PLL_CTRL      9'h120
`define BSCR_IDX_LOOPBACK      9'h122

// fixed read values and reset values
`define BSCR_TEST_ONE_VAL      16'hAA55
`define BSCR_TEST_TWO_VAL      16'hDEAD
`define BSCR_ZERO_RST          16'h0000
`define BSCR_LED_RST           16'h0007
`define BSCR_REF_ZERO_RST      16'h0011
`define BSCR_RSVD_A_RST        16'h00B7

// writable bit masks and the error counter limit
`define BSCR_FULL_MASK         16'hFFFF
`define BSCR_LED_MASK          16'h00FF
`define BSCR_LOOPBACK_MASK     16'h000F
`define BSCR_UNIT_RESET_MASK   16'h805F
`define BSCR_COUNT_MAX         16'hFFFF

`endif

// ==== pkg/bscr_pkg.sv ====
// types shared by the board status and control register bank
`default_nettype none
package bscr_pkg;

	// pll and link status levels
	typedef struct packed {
		logic       pcie_link_active;
		logic       autoneg_done;
		logic       pll_locked;
		logic       pll_holdover;
		logic [1:0] pll_reference_failed;
		logic       pll_reference_chosen;
	} bscr_link_status_type;

	// every level that arrives on a board pin
	typedef struct packed {
		logic [3:0]           board_major_version;
		logic [3:0]           board_minor_version;
		logic                 second_sram_fitted;
		logic                 first_sram_fitted;
		logic [1:0]           trunk_count_code;
		bscr_link_status_type link;
		logic [7:0]           carrier_manager_code;
		logic [7:0]           slot_address;
	} bscr_pins_type;

endpackage : bscr_pkg
`default_nettype wire

// ==== src/bscr_regs.sv ====
// board status and control register bank behind an apb slave
`timescale 1ns/1ps
`default_nettype none
`include "bscr_map.svh"

module bscr_regs #(
	parameter int          ADDR_W       = 12,
	parameter logic [7:0]  LOGIC_TYPE   = 8'h5A,   // arbitrary value
	parameter logic [15:0] BOARD_IDENT  = 16'h1234, // arbitrary value
	parameter logic [7:0]  LOGIC_SUB    = 8'h01,
	parameter logic [3:0]  LOGIC_MAJOR  = 4'h1,
	parameter logic [3:0]  LOGIC_MINOR  = 4'h0
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire bscr_pkg::bscr_pins_type pins,
	input  wire logic [15:0]           irq_source,
	input  wire logic                  ethernet_error_pulse,
	input  wire logic                  coding_error_pulse,
	output logic      [15:0]           unit_reset_pulse,
	output logic      [3:0]            led_orange_field,
	output logic      [3:0]            led_green_field,
	output logic      [15:0]           interrupt_enable,
	output logic      [15:0]           telecom_clock_a_control,
	output logic      [15:0]           telecom_clock_b_control,
	output logic      [15:0]           telecom_clock_c_control,
	output logic      [15:0]           telecom_clock_d_control,
	output logic      [15:0]           pll_reference_zero_select,
	output logic      [15:0]           pll_reference_one_select,
	output logic      [15:0]           pll_control,
	output logic      [3:0]            tdm_loopback_enables
);

	////////////////////////////////////////////////////////////////////
	// constants and decode

	localparam int RW_N = 13;
	localparam logic [8:0] RW_IDX [RW_N] = '{
		`BSCR_IDX_LED_CTRL, `BSCR_IDX_IRQ_ENABLE, `BSCR_IDX_TCLK_A,
		`BSCR_IDX_TCLK_B, `BSCR_IDX_TCLK_C, `BSCR_IDX_TCLK_D,
		`BSCR_IDX_REF_ZERO, `BSCR_IDX_REF_ONE, `BSCR_IDX_UNDEFINED,
		`BSCR_IDX_RSVD_A, `BSCR_IDX_RSVD_B, `BSCR_IDX_PLL_CTRL,
		`BSCR_IDX_LOOPBACK};
	localparam logic [15:0] RW_RST [RW_N] = '{
		`BSCR_LED_RST, `BSCR_ZERO_RST, `BSCR_ZERO_RST,
		`BSCR_ZERO_RST, `BSCR_ZERO_RST, `BSCR_ZERO_RST,
		`BSCR_REF_ZERO_RST, `BSCR_ZERO_RST, `BSCR_ZERO_RST,
		`BSCR_RSVD_A_RST, `BSCR_ZERO_RST, `BSCR_ZERO_RST,
		`BSCR_ZERO_RST};
	localparam logic [15:0] RW_MASK [RW_N] = '{
		`BSCR_LED_MASK, `BSCR_FULL_MASK, `BSCR_FULL_MASK,
		`BSCR_FULL_MASK, `BSCR_FULL_MASK, `BSCR_FULL_MASK,
		`BSCR_FULL_MASK, `BSCR_FULL_MASK, `BSCR_FULL_MASK,
		`BSCR_FULL_MASK, `BSCR_FULL_MASK, `BSCR_FULL_MASK,
		`BSCR_LOOPBACK_MASK};

	// word index of a byte address, all ones when out of range
	function automatic logic [8:0] bscr_word_index(
		input logic [ADDR_W-1:0] addr
	);
		logic [ADDR_W-1:0] upper;
		upper = addr >> 11;
		if (upper != '0)
			bscr_word_index = 9'h1FF;
		else
			bscr_word_index = addr[10:2];
	endfunction : bscr_word_index

	// read value of a word, with a flag for mapped words
	logic [15:0] ctrl_ff [RW_N];
	logic [15:0] unit_reset_ff;
	logic [15:0] irq_status_ff;
	logic [15:0] eth_count_ff;
	logic [15:0] pcs_count_ff;
	bscr_pkg::bscr_pins_type pins_meta_ff;
	bscr_pkg::bscr_pins_type pins_ff;

	function automatic logic [16:0] bscr_read_word(input logic [8:0] idx);
		logic [16:0] rv;
		rv = {1'b1, 16'h0000};
		unique case (idx)
			`BSCR_IDX_TYPE_BOARD: rv[15:0] = {LOGIC_TYPE,
				pins_ff.board_major_version,
				pins_ff.board_minor_version};
			`BSCR_IDX_LOGIC_REV: rv[15:0] = {LOGIC_SUB, LOGIC_MAJOR,
				LOGIC_MINOR};
			`BSCR_IDX_TEST_ONE: rv[15:0] = `BSCR_TEST_ONE_VAL;
			`BSCR_IDX_TEST_TWO: rv[15:0] = `BSCR_TEST_TWO_VAL;
			`BSCR_IDX_BOARD_IDENTITY: rv[15:0] = BOARD_IDENT;
			`BSCR_IDX_ASSEMBLY: rv[15:0] = {12'h000,
				pins_ff.second_sram_fitted, pins_ff.first_sram_fitted,
				pins_ff.trunk_count_code};
			`BSCR_IDX_IRQ_STATUS: rv[15:0] = irq_status_ff;
			`BSCR_IDX_PLL_STATUS: rv[15:0] = {6'h00,
				pins_ff.link.pcie_link_active,
				pins_ff.link.autoneg_done, 3'h0,
				pins_ff.link.pll_locked, pins_ff.link.pll_holdover,
				pins_ff.link.pll_reference_failed,
				pins_ff.link.pll_reference_chosen};
			`BSCR_IDX_CARRIER_SLOT: rv[15:0] = {
				pins_ff.carrier_manager_code,
				pins_ff.slot_address};
			`BSCR_IDX_ETH_ERRORS: rv[15:0] = eth_count_ff;
			`BSCR_IDX_PCS_ERRORS: rv[15:0] = pcs_count_ff;
			`BSCR_IDX_UNIT_RESET: rv[15:0] = unit_reset_ff;
			default: begin
				rv = 17'h00000;
				for (int i = 0; i < RW_N; i++) begin
					if (idx == RW_IDX[i])
						rv = {1'b1, ctrl_ff[i]};
				end
			end
		endcase
		bscr_read_word = rv;
	endfunction : bscr_read_word

	////////////////////////////////////////////////////////////////////
	// apb slave

	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] prdata_ff;
	logic [8:0]  widx;
	logic [16:0] rd_word;
	logic        access_start;
	logic        wr_commit;

	assign widx         = bscr_word_index(paddr);
	assign rd_word      = bscr_read_word(widx);
	assign access_start = psel && penable && !pready_ff;
	assign wr_commit    = psel && penable && pready_ff && pwrite;

	// answer one cycle into the access phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else if (access_start) begin
			pready_ff  <= 1'b1;
			pslverr_ff <= !rd_word[16];
			prdata_ff  <= pwrite ? 32'h00000000 : {16'h0000, rd_word[15:0]};
		end else begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;

	////////////////////////////////////////////////////////////////////
	// pin synchroniser and status capture

	// two stages before any logic reads the board pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pins_meta_ff <= '0;
			pins_ff      <= '0;
		end else begin
			pins_meta_ff <= pins;
			pins_ff      <= pins_meta_ff;
		end
	end

	// interrupt sources from same-clock logic
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			irq_status_ff <= `BSCR_ZERO_RST;
		else
			irq_status_ff <= irq_source;
	end

	// saturating error counters
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			eth_count_ff <= `BSCR_ZERO_RST;
			pcs_count_ff <= `BSCR_ZERO_RST;
		end else begin
			if (ethernet_error_pulse && eth_count_ff != `BSCR_COUNT_MAX)
				eth_count_ff <= eth_count_ff + 16'h0001;
			if (coding_error_pulse && pcs_count_ff != `BSCR_COUNT_MAX)
				pcs_count_ff <= pcs_count_ff + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// writable words and reset pulses

	// read/write control words; read-only words have no write path
	for (genvar g = 0; g < RW_N; g++) begin : g_rw
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn)
				ctrl_ff[g] <= RW_RST[g];
			else if (wr_commit && widx == RW_IDX[g])
				ctrl_ff[g] <= pwdata[15:0] & RW_MASK[g];
		end
	end

	// one-cycle pulse per written one inside BSCR_UNIT_RESET_MASK, cleared without software
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			unit_reset_ff <= `BSCR_ZERO_RST;
		else if (wr_commit && widx == `BSCR_IDX_UNIT_RESET)
			unit_reset_ff <= pwdata[15:0] & `BSCR_UNIT_RESET_MASK;
		else
			unit_reset_ff <= `BSCR_ZERO_RST;
	end

	// outputs taken straight from the flip-flops
	assign unit_reset_pulse          = unit_reset_ff;
	assign led_orange_field          = ctrl_ff[0][7:4];
	assign led_green_field           = ctrl_ff[0][3:0];
	assign interrupt_enable          = ctrl_ff[1];
	assign telecom_clock_a_control   = ctrl_ff[2];
	assign telecom_clock_b_control   = ctrl_ff[3];
	assign telecom_clock_c_control   = ctrl_ff[4];
	assign telecom_clock_d_control   = ctrl_ff[5];
	assign pll_reference_zero_select = ctrl_ff[6];
	assign pll_reference_one_select  = ctrl_ff[7];
	assign pll_control               = ctrl_ff[11];
	assign tdm_loopback_enables      = ctrl_ff[12][3:0];

	////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	logic rd_start;
	assign rd_start = access_start && !pwrite;

	property p_pulse_single;
		(unit_reset_ff != 16'h0000) |=> (unit_reset_ff == 16'h0000);
	endproperty
	a_pulse_single: assert property (p_pulse_single)
		else $error("reset pulse held longer than one cycle");

	property p_pulse_from_write;
		(wr_commit && widx == `BSCR_IDX_UNIT_RESET)
			|=> (unit_reset_ff == ($past(pwdata[15:0]) & 16'h805F));
	endproperty
	a_pulse_from_write: assert property (p_pulse_from_write)
		else $error("reset pulse does not match written bits");

	property p_pulse_len;
		$rose(unit_reset_ff[0]) |-> unit_reset_ff[0] ##1 !unit_reset_ff[0];
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("reset pulse width wrong");

	property p_test_one;
		(rd_start && widx == `BSCR_IDX_TEST_ONE)
			|=> pready_ff && prdata_ff == 32'h0000AA55;
	endproperty
	a_test_one: assert property (p_test_one)
		else $error("first test word wrong");

	property p_test_two;
		(rd_start && widx == `BSCR_IDX_TEST_TWO)
			|=> prdata_ff == 32'h0000DEAD;
	endproperty
	a_test_two: assert property (p_test_two)
		else $error("second test word wrong");

	property p_board_version;
		(rd_start && widx == `BSCR_IDX_TYPE_BOARD)
			|=> prdata_ff[7:0] == $past({pins_ff.board_major_version,
				pins_ff.board_minor_version});
	endproperty
	a_board_version: assert property (p_board_version)
		else $error("board version field wrong");

	property p_slot;
		(rd_start && widx == `BSCR_IDX_CARRIER_SLOT)
			|=> prdata_ff[15:0] == $past({pins_ff.carrier_manager_code,
				pins_ff.slot_address});
	endproperty
	a_slot: assert property (p_slot)
		else $error("carrier and slot word wrong");

	property p_led_write;
		(wr_commit && widx == `BSCR_IDX_LED_CTRL) |=>
			{led_orange_field, led_green_field} == $past(pwdata[7:0]);
	endproperty
	a_led_write: assert property (p_led_write)
		else $error("led fields not updated");

	property p_loop_reserved;
		(rd_start && widx == `BSCR_IDX_LOOPBACK)
			|=> prdata_ff[31:4] == 28'h0000000;
	endproperty
	a_loop_reserved: assert property (p_loop_reserved)
		else $error("loopback reserved bits not zero");

	property p_count_step;
		(ethernet_error_pulse && eth_count_ff != 16'hFFFF)
			|=> eth_count_ff == $past(eth_count_ff) + 16'h0001;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("ethernet error count did not step");

	property p_ro_kept;
		(wr_commit && widx == `BSCR_IDX_TEST_ONE) ##[1:8]
			(rd_start && widx == `BSCR_IDX_TEST_ONE)
			|=> prdata_ff[15:0] == 16'hAA55;
	endproperty
	a_ro_kept: assert property (p_ro_kept)
		else $error("write changed a read-only word");

	property p_answer_once;
		pready_ff |=> !pready_ff;
	endproperty
	a_answer_once: assert property (p_answer_once)
		else $error("ready held for more than one cycle");

	property p_coding_step;
		(coding_error_pulse && pcs_count_ff != 16'hFFFF)
			|=> pcs_count_ff == $past(pcs_count_ff) + 16'h0001;
	endproperty
	a_coding_step: assert property (p_coding_step)
		else $error("coding error count did not step");

	// a full ethernet error counter must stay full, never wrap to zero
	property p_count_hold;
		(eth_count_ff == 16'hFFFF) |=> (eth_count_ff == 16'hFFFF);
	endproperty
	a_count_hold: assert property (p_count_hold)
		else $error("ethernet error count left saturation");

	// words above the last mapped index answer with an error
	property p_unmapped_err;
		(access_start && widx > `BSCR_IDX_LOOPBACK)
			|=> pslverr_ff && prdata_ff == 32'h00000000;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("unmapped word answered without error");

	property p_irq_mirror;
		1'b1 |=> irq_status_ff == $past(irq_source);
	endproperty
	a_irq_mirror: assert property (p_irq_mirror)
		else $error("interrupt status does not follow its sources");

	c_reset_pulse: cover property (unit_reset_ff[15]);
	c_test_read: cover property (rd_start && widx == `BSCR_IDX_TEST_ONE);
	c_unmapped: cover property (pready_ff && pslverr_ff);
	c_count_full: cover property (eth_count_ff == 16'hFFFF);
	c_led_write: cover property (wr_commit && widx == `BSCR_IDX_LED_CTRL);

endmodule : bscr_regs
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the board status and control register bank
`timescale 1ns/1ps
`default_nettype none
`include "bscr_map.svh"

module testbench;
	localparam logic [7:0]  TYPE_V  = 8'h5A;    // arbitrary value
	localparam logic [15:0] IDENT_V = 16'h1234; // arbitrary value

	logic                    clk;
	logic                    resetn;
	logic [11:0]             paddr;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [31:0]             pwdata;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	bscr_pkg::bscr_pins_type pins;
	bscr_pkg::bscr_pins_type pv;
	logic [15:0]             irq_source;
	logic                    eth_pulse;
	logic                    cod_pulse;
	logic [15:0]             unit_reset_pulse;
	logic [3:0]              led_orange_field;
	logic [3:0]              led_green_field;
	logic [15:0]             irq_en;
	logic [15:0]             tclk_a;
	logic [15:0]             tclk_b;
	logic [15:0]             tclk_c;
	logic [15:0]             tclk_d;
	logic [15:0]             ref_zero;
	logic [15:0]             ref_one;
	logic [15:0]             pll_ctrl;
	logic [3:0]              loopback;
	int                      err_count;
	int                      check_count;
	logic [15:0]             model [0:511];
	logic [8:0]              rw_idx [13] = '{9'h102, 9'h10C, 9'h10E, 9'h110,
		9'h112, 9'h114, 9'h116, 9'h118, 9'h11A, 9'h11C, 9'h11E, 9'h120, 9'h122};

	bscr_regs #(.LOGIC_TYPE(TYPE_V), .BOARD_IDENT(IDENT_V), .LOGIC_SUB(8'h01),
		.LOGIC_MAJOR(4'h1), .LOGIC_MINOR(4'h0)) bscr_regs_inst (
		.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
		.irq_source(irq_source), .ethernet_error_pulse(eth_pulse),
		.coding_error_pulse(cod_pulse), .unit_reset_pulse(unit_reset_pulse),
		.led_orange_field(led_orange_field), .led_green_field(led_green_field),
		.interrupt_enable(irq_en), .telecom_clock_a_control(tclk_a),
		.telecom_clock_b_control(tclk_b), .telecom_clock_c_control(tclk_c),
		.telecom_clock_d_control(tclk_d), .pll_reference_zero_select(ref_zero),
		.pll_reference_one_select(ref_one), .pll_control(pll_ctrl),
		.tdm_loopback_enables(loopback));

	// free-running system clock
	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// compare one value and count the outcome
	task automatic chk(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// one apb transfer: setup, access, wait for pready
	task automatic apb(input logic wr, input logic [8:0] idx,
			input logic [15:0] wd, output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {1'b0, idx, 2'b00};
		pwdata  <= {16'($urandom), wd}; // upper half must be ignored
		@(posedge clk);
		penable <= 1'b1;
		// no bound here: only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// read a word and compare data and error flag
	task automatic rd_chk(input string name, input logic [8:0] idx,
			input logic [15:0] exp, input int experr);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, idx, 16'h0000, rd, err);
		chk(name, rd, {16'h0000, exp});
		chk({name, "_err"}, {31'h0, err}, experr);
	endtask : rd_chk

	// write a word and compare the error flag
	task automatic wr(input logic [8:0] idx, input logic [15:0] wd,
			input int experr);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, idx, wd, rd, err);
		chk("write_err", {31'h0, err}, experr);
	endtask : wr

	function automatic logic [15:0] mask_of(input logic [8:0] idx);
		case (idx)
			9'h102:  return 16'h00FF;
			9'h122:  return 16'h000F;
			default: return 16'hFFFF;
		endcase
	endfunction : mask_of

	// verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake, well past the expected run
	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		$display("Error watchdog expected done seen timeout");
		report_and_stop();
	end

	// main sequence
	initial begin
		logic [15:0] wd;
		int          n;
		clk = 1'b0; resetn = 1'b0; psel = 1'b0; penable = 1'b0;
		pwrite = 1'b0; paddr = '0; pwdata = '0; pins = '0; irq_source = '0;
		eth_pulse = 1'b0; cod_pulse = 1'b0; err_count = 0; check_count = 0;
		void'($urandom(63132));
		foreach (model[i]) model[i] = 16'h0000;
		model[9'h102] = 16'h0007; model[9'h116] = 16'h0011;
		model[9'h11C] = 16'h00B7;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		chk("led_green", led_green_field, 32'h7);
		chk("ref_zero", ref_zero, 32'h0011);
		foreach (rw_idx[i]) rd_chk("rw_reset", rw_idx[i],
				model[rw_idx[i]], 0);
		rd_chk("test_one", 9'h004, 16'hAA55, 0);
		rd_chk("test_two", 9'h006, 16'hDEAD, 0);
		rd_chk("revision", 9'h002, 16'h0110, 0);
		rd_chk("identity", 9'h008, IDENT_V, 0);
		// strap and status pins, all trunk codes, slot and carrier codes
		for (int k = 0; k < 4; k++) begin
			pv = bscr_pkg::bscr_pins_type'({$urandom, $urandom});
			pv.trunk_count_code = 2'(k);
			pv.slot_address = (k == 3) ? 8'h88 : 8'h72 + 8'(2 * k);
			pv.carrier_manager_code = 8'h80 + 8'(2 * k);
			pins <= pv;
			irq_source <= 16'($urandom);
			repeat (4) @(posedge clk);
			wr(9'h000, 16'($urandom), 0);
			wr(9'h004, 16'($urandom), 0);
			rd_chk("test_one_ro", 9'h004, 16'hAA55, 0);
			rd_chk("board_ver", 9'h000, {TYPE_V,
				pv.board_major_version, pv.board_minor_version}, 0);
			rd_chk("assembly", 9'h00A, {12'h000,
				pv.second_sram_fitted, pv.first_sram_fitted,
				pv.trunk_count_code}, 0);
			rd_chk("pll_stat", 9'h00E, {6'h00,
				pv.link.pcie_link_active, pv.link.autoneg_done, 3'b000,
				pv.link.pll_locked, pv.link.pll_holdover,
				pv.link.pll_reference_failed,
				pv.link.pll_reference_chosen}, 0);
			rd_chk("carrier_slot", 9'h010,
				{pv.carrier_manager_code, pv.slot_address}, 0);
			rd_chk("irq_stat", 9'h00C, irq_source, 0);
		end
		// read/write words: random data then all ones for reserved bits
		for (int p = 0; p < 2; p++) begin
			foreach (rw_idx[i]) begin
				wd = (p == 0) ? 16'($urandom) : 16'hFFFF;
				wr(rw_idx[i], wd, 0);
				model[rw_idx[i]] = wd & mask_of(rw_idx[i]);
				rd_chk("rw_back", rw_idx[i],
					model[rw_idx[i]], 0);
			end
			@(posedge clk);
			chk("led", {led_orange_field, led_green_field}, model[9'h102]);
			chk("irq_en", irq_en, model[9'h10C]);
			chk("tclk", {tclk_a, tclk_b},
				{model[9'h10E], model[9'h110]});
			chk("tclk", {tclk_c, tclk_d},
				{model[9'h112], model[9'h114]});
			chk("ref", {ref_zero, ref_one},
				{model[9'h116], model[9'h118]});
			chk("pll_ctrl", pll_ctrl, model[9'h120]);
			chk("loopback", loopback, model[9'h122]);
		end
		// unit reset pulses: one cycle each, then self-clearing
		for (int p = 0; p < 3; p++) begin
			wd = (p == 0) ? 16'hFFFF : 16'($urandom);
			wr(9'h100, wd, 0);
			@(posedge clk);
			chk("reset_pulse", unit_reset_pulse,
				wd & 16'h805F);
			@(posedge clk);
			chk("reset_clear", unit_reset_pulse, 32'h0);
			rd_chk("reset_word", 9'h100, 16'h0000, 0);
		end
		// error counters: a short burst and a saturating one
		n = 1 + ($urandom % 40);
		repeat (n) @(posedge clk) cod_pulse <= 1'b1;
		@(posedge clk) cod_pulse <= 1'b0;
		repeat (65537) @(posedge clk) eth_pulse <= 1'b1;
		@(posedge clk) eth_pulse <= 1'b0;
		wr(9'h022, 16'h0000, 0);
		rd_chk("coding_cnt", 9'h022, 16'(n), 0);
		rd_chk("eth_cnt", 9'h020, 16'hFFFF, 0);
		// unmapped places answer with an error
		rd_chk("unmapped", 9'h030, 16'h0000, 1);
		wr(9'h124, 16'hFFFF, 1);
		rd_chk("unmapped", 9'h124, 16'h0000, 1);
		report_and_stop();
	end

endmodule : testbench
`default_nettype wire
